// [rtl/cgs_global_regs.sv]
// apb register slice: error flags, enables, group b alarms and rate modes
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "cgs_defines.svh"

// Operation
// - raise frame offset error when any two channels differ by over 17 bytes
// - phase spread is checked on every receive cycle
// - write to a protected address while map locked sets locked-write error
// - writes to lock registers or scratch pad never set that error
// - writing one clears an error flag, zero leaves it; both reset to zero
// - enable bit 0 gates the frame offset error interrupt, not the flag; resets to zero
// - enable bit 1 gates the locked-write error interrupt, not the flag; resets to zero
// - bits 0 to 3 show group b channel alarms, read only
// - two-bit rate field per group: a at 1:0, b at 3:2
module cgs_global_regs
(
  // clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [19:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  // receive phase monitor
  input  wire logic                rx_active,
  input  wire cgs_pkg::cgs_phase_t rx_phase [`CGS_NUM_CHANNELS],
  // channel alarm consolidation, group b
  input  wire logic [3:0]          group_b_alarm,
  // lock state of the core map
  input  wire logic                map_locked,
  // rate mode per four-channel group
  output logic [1:0]               quad_group_first_mode,
  output logic [1:0]               quad_group_second_mode,
  // combined event
  output logic                     core_event_irq
);
  import cgs_pkg::*;

  // register state
  logic [1:0]  core_error_flags;
  logic [1:0]  core_error_enables;
  logic [3:0]  group_b_channel_alarms;
  logic [3:0]  group_rate_mode;

  // next values
  logic [1:0]  next_core_error_flags;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;

  // bus decode
  cgs_index_t  reg_index;
  wire         word_aligned;
  wire         access_phase;
  wire         xfer_done;
  wire         wr_fire;
  wire         hit_flags;
  wire         hit_enables;
  wire         hit_alarms;
  wire         hit_reserved;
  wire         hit_rate;
  wire         hit_mapped;
  wire         hit_exempt;

  // event sources
  wire         frame_ofs_over;
  wire         set_frame_ofs;
  wire         set_locked_wr;
  wire [1:0]   set_flags;
  wire [1:0]   clr_flags;
  wire [1:0]   enabled_flags;

  // read path
  wire [31:0]  rd_flags;
  wire [31:0]  rd_enables;
  wire [31:0]  rd_alarms;
  wire [31:0]  rd_rate;
  wire [31:0]  rd_word;

  assign reg_index    = paddr[19:2];
  assign word_aligned = (paddr[1:0] == 2'h0);

  assign hit_flags    = word_aligned && (reg_index == `CGS_IDX_ERR_FLAGS);
  assign hit_enables  = word_aligned && (reg_index == `CGS_IDX_ERR_ENABLES);
  assign hit_alarms   = word_aligned && (reg_index == `CGS_IDX_B_ALARMS);
  assign hit_reserved = word_aligned && (reg_index == `CGS_IDX_RESERVED);
  assign hit_rate     = word_aligned && (reg_index == `CGS_IDX_RATE_MODE);

  assign hit_mapped   = hit_flags || hit_enables || hit_alarms
                      || hit_reserved || hit_rate;

  // lock and scratch pad stay writable while the map is locked
  assign hit_exempt   = word_aligned
                      && ((reg_index == `CGS_IDX_LOCK_0)
                      ||  (reg_index == `CGS_IDX_LOCK_1)
                      ||  (reg_index == `CGS_IDX_SCRATCH));

  // one wait state: pready rises on the second access cycle
  assign access_phase = psel && penable;
  assign xfer_done    = access_phase && pready;
  assign wr_fire      = xfer_done && pwrite;

  // spread monitor
  cgs_phase_spread u_phase_spread
  (
    .pclk       (pclk),
    .presetn    (presetn),
    .rx_active  (rx_active),
    .rx_phase   (rx_phase),
    .over_limit (frame_ofs_over)
  );

  // events
  assign set_frame_ofs = frame_ofs_over;
  assign set_locked_wr = wr_fire && map_locked && !hit_exempt;

  assign set_flags[`CGS_BIT_FRAME_OFS] = set_frame_ofs;
  assign set_flags[`CGS_BIT_LOCKED_WR] = set_locked_wr;

  // write one to clear; zero bits leave the flag alone
  assign clr_flags = (wr_fire && hit_flags) ? pwdata[1:0] : 2'h0;

  // a new event in the clearing cycle survives the clear
  assign next_core_error_flags = (core_error_flags & ~clr_flags) | set_flags;

  assign enabled_flags = core_error_flags & core_error_enables;

  // read words, upper bits read as zero
  assign rd_flags   = {30'h0, core_error_flags};
  assign rd_enables = {30'h0, core_error_enables};
  assign rd_alarms  = {28'h0, group_b_channel_alarms};
  assign rd_rate    = {28'h0, group_rate_mode};

  assign rd_word = hit_flags   ? rd_flags   :
                   hit_enables ? rd_enables :
                   hit_alarms  ? rd_alarms  :
                   hit_rate    ? rd_rate    :
                   32'h0;

  // bus answer is prepared while pready is low, then held with it
  always_comb
  begin
    next_pready  = access_phase && !pready;
    next_prdata  = prdata;
    next_pslverr = 1'b0;
    if (access_phase && !pready)
    begin
      next_prdata  = pwrite ? 32'h0 : rd_word;
      next_pslverr = !hit_mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end
    else
    begin
      pready  <= next_pready;
      pslverr <= next_pslverr;
      prdata  <= next_prdata;
    end
  end

  // sticky error flags
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      core_error_flags <= `CGS_RST_ERR_FLAGS;
    else
      core_error_flags <= next_core_error_flags;
  end

  // flag enables, used only as the interrupt mask; flags set regardless
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      core_error_enables <= `CGS_RST_ERR_ENABLES;
    else if (wr_fire && hit_enables)
      core_error_enables <= pwdata[1:0];
  end

  // alarms come from same-clock logic, captured for a stable read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      group_b_channel_alarms <= `CGS_RST_B_ALARMS;
    else
      group_b_channel_alarms <= group_b_alarm;
  end

  // rate mode fields; codes other than 00 and 10 are kept as written
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      group_rate_mode <= `CGS_RST_RATE_MODE;
    else if (wr_fire && hit_rate)
      group_rate_mode <= pwdata[3:0];
  end

  // mode outputs follow the register, one flop stage for clean timing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      quad_group_first_mode  <= cgs_rate_12_48;
      quad_group_second_mode <= cgs_rate_12_48;
    end
    else
    begin
      quad_group_first_mode  <= group_rate_mode[`CGS_RATE_A_LSB +: 2];
      quad_group_second_mode <= group_rate_mode[`CGS_RATE_B_LSB +: 2];
    end
  end

  // level interrupt, lags the flags by one cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      core_event_irq <= 1'b0;
    else
      core_event_irq <= |enabled_flags;
  end

endmodule // cgs_global_regs
`default_nettype wire

// [rtl/cgs_defines.svh]
// register indices, field positions, reset values and limits of the global status slice
`ifndef CGS_DEFINES_SVH
`define CGS_DEFINES_SVH

// register indices; byte address on the bus is four times the index
`define CGS_IDX_ERR_FLAGS    18'h30012
`define CGS_IDX_ERR_ENABLES  18'h30013
`define CGS_IDX_B_ALARMS     18'h30014
`define CGS_IDX_RESERVED     18'h30015
`define CGS_IDX_RATE_MODE    18'h30016

// addresses that a locked map still accepts without complaint
`define CGS_IDX_LOCK_0       18'h30001
`define CGS_IDX_LOCK_1       18'h30002
`define CGS_IDX_SCRATCH      18'h30003

// field positions
`define CGS_BIT_FRAME_OFS    0
`define CGS_BIT_LOCKED_WR    1
`define CGS_RATE_A_LSB       0
`define CGS_RATE_B_LSB       2

// reset values
`define CGS_RST_ERR_FLAGS    2'h0
`define CGS_RST_ERR_ENABLES  2'h0
`define CGS_RST_B_ALARMS     4'h0
`define CGS_RST_RATE_MODE    4'h0

// largest legal receive phase spread between two channels, in bytes
`define CGS_FRAME_OFS_MAX    8'h11
`define CGS_NUM_CHANNELS     8

`endif

// [rtl/cgs_pkg.sv]
// types shared by the global status slice
package cgs_pkg;

  typedef logic [7:0] cgs_phase_t;

  typedef logic [17:0] cgs_index_t;

  typedef enum logic [1:0]
  {
    cgs_rate_12_48 = 2'b00,
    cgs_rate_3     = 2'b10
  } cgs_rate_code_t;

endpackage

// [rtl/cgs_phase_spread.sv]
// receive phase spread monitor across all channels
`timescale 1ns/1ps
`default_nettype none
`include "cgs_defines.svh"

module cgs_phase_spread
(
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // receive alignment phases
  input  wire logic               rx_active,
  input  wire cgs_pkg::cgs_phase_t rx_phase [`CGS_NUM_CHANNELS],
  // result
  output logic                    over_limit
);
  import cgs_pkg::*;

  cgs_phase_t phase_max;
  cgs_phase_t phase_min;
  cgs_phase_t spread;

  // extremes over every channel give the worst pair at once
  always_comb
  begin
    phase_max = rx_phase[0];
    phase_min = rx_phase[0];
    for (int i = 1; i < `CGS_NUM_CHANNELS; i++)
    begin
      if (rx_phase[i] > phase_max)
        phase_max = rx_phase[i];
      if (rx_phase[i] < phase_min)
        phase_min = rx_phase[i];
    end
  end

  assign spread = phase_max - phase_min;

  // judged on every cycle of receive, not on a sampling tick
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      over_limit <= 1'b0;
    else
      over_limit <= rx_active && (spread > `CGS_FRAME_OFS_MAX);
  end

endmodule // cgs_phase_spread
`default_nettype wire

// [testbench/cgs_global_regs_monitor.sv]
// checker of bus timing, read values and outputs of the global status slice
`timescale 1ns/1ps
`default_nettype none
module cgs_global_regs_monitor
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [19:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // alarms and outputs
  input wire logic [3:0]  group_b_alarm,
  input wire logic [1:0]  quad_group_first_mode,
  input wire logic [1:0]  quad_group_second_mode,
  input wire logic        core_event_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire done = psel && penable && pready;
  wire rd_done = done && !pwrite;

  one_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("ready not after one wait state");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  reset_quiet_a: assert property ($rose(presetn) |-> !core_event_irq
    && quad_group_first_mode == 2'h0 && quad_group_second_mode == 2'h0)
    else $error("outputs not zero after reset");
  irq_mask_a: assert property (done && pwrite && paddr == 20'hc004c
    && pwdata[1:0] == 2'h0 |=> ##1 !core_event_irq) else $error("irq despite mask");
  rate_follow_a: assert property (done && pwrite && paddr == 20'hc0058
    |=> ##1 {quad_group_second_mode, quad_group_first_mode} == $past(pwdata[3:0], 2))
    else $error("rate outputs wrong");
  alarm_read_a: assert property (rd_done && paddr == 20'hc0050 && $stable(group_b_alarm)
    && group_b_alarm == $past(group_b_alarm, 2) && group_b_alarm == $past(group_b_alarm, 3)
    |-> prdata == {28'h0, group_b_alarm}) else $error("alarm read wrong");
  enable_width_a: assert property (rd_done && paddr == 20'hc004c
    |-> prdata[31:2] == 30'h0 && !pslverr) else $error("enable read wrong");
  reserved_read_a: assert property (rd_done && paddr == 20'hc0054
    |-> prdata == 32'h0 && !pslverr) else $error("reserved read wrong");
endmodule // cgs_global_regs_monitor

bind cgs_global_regs cgs_global_regs_monitor u_cgs_global_regs_monitor (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .group_b_alarm(group_b_alarm), .quad_group_first_mode(quad_group_first_mode),
  .quad_group_second_mode(quad_group_second_mode), .core_event_irq(core_event_irq));
`default_nettype wire

// [testbench/core_global_status_mode_regs_tb_top.sv]
// self-checking bench for the global status slice
`timescale 1ns/1ps
`default_nettype none
`include "cgs_defines.svh"
module core_global_status_mode_regs_tb_top;
  import cgs_pkg::*;
  localparam logic [19:0] a_flg = {`CGS_IDX_ERR_FLAGS, 2'b00};
  localparam logic [19:0] a_ena = {`CGS_IDX_ERR_ENABLES, 2'b00};
  localparam logic [19:0] a_alm = {`CGS_IDX_B_ALARMS, 2'b00};
  localparam logic [19:0] a_rsv = {`CGS_IDX_RESERVED, 2'b00};
  localparam logic [19:0] a_rate = {`CGS_IDX_RATE_MODE, 2'b00};
  localparam logic [19:0] a_free [3] = '{{`CGS_IDX_LOCK_0, 2'b00},
    {`CGS_IDX_LOCK_1, 2'b00}, {`CGS_IDX_SCRATCH, 2'b00}};
  localparam logic [3:0]  rates [4] = '{4'h0, 4'h2, 4'h8, 4'ha};
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [19:0] paddr = 20'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rx_active = 1'b0;
  cgs_phase_t  rx_phase [`CGS_NUM_CHANNELS];
  logic [3:0]  group_b_alarm = 4'h0;
  logic        map_locked = 1'b0;
  logic [1:0]  quad_group_first_mode;
  logic [1:0]  quad_group_second_mode;
  logic        core_event_irq;
  logic [31:0] rdat;
  logic        perr;
  int          mismatches = 0;
  int          num_checks = 0;
  int          cyc = 0;

  always #5 pclk = ~pclk;

  cgs_global_regs u_cgs_global_regs (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_active(rx_active), .rx_phase(rx_phase),
    .group_b_alarm(group_b_alarm), .map_locked(map_locked),
    .quad_group_first_mode(quad_group_first_mode),
    .quad_group_second_mode(quad_group_second_mode), .core_event_irq(core_event_irq));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // bounded wait so a silent slave cannot hang the run
  task automatic xfer(input logic w, input logic [19:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // look between edges so the answer is read settled, not in its launch step
    do
    begin
      @(negedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 10);
    if (n == 10)
    begin
      mismatches++;
      close_out();
    end
    rdat = prdata;
    perr = pslverr;
    // completion edge: the write lands here, only then is the request dropped
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [19:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask

  task automatic note(input string s);
    $display("test %s done", s);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      mismatches++;
      close_out();
    end
  end

  initial
  begin
    foreach (rx_phase[i])
      rx_phase[i] = 8'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(a_flg, 32'h0);
    rd(a_ena, 32'h0);
    rd(a_rate, 32'h0);
    xfer(1'b1, a_ena, 32'hff);
    rd(a_ena, 32'h3);
    note("reset and enables");
    rx_active <= 1'b1;
    rx_phase[5] <= 8'h11;
    repeat (4) @(posedge pclk);
    rd(a_flg, 32'h0);
    rx_phase[2] <= 8'h12;
    @(posedge pclk);
    rx_phase[2] <= 8'h0;
    repeat (3) @(posedge pclk);
    chk({31'h0, core_event_irq}, 32'h1);
    rd(a_flg, 32'h1);
    xfer(1'b1, a_ena, 32'h2);
    @(posedge pclk);
    chk({31'h0, core_event_irq}, 32'h0);
    xfer(1'b1, a_flg, 32'h0);
    rd(a_flg, 32'h1);
    xfer(1'b1, a_flg, 32'h1);
    rd(a_flg, 32'h0);
    note("frame offset");
    map_locked <= 1'b1;
    foreach (a_free[i])
      xfer(1'b1, a_free[i], 32'h5a);
    rd(a_flg, 32'h0);
    xfer(1'b1, a_rate, 32'h8);
    rd(a_flg, 32'h2);
    chk({31'h0, core_event_irq}, 32'h1);
    map_locked <= 1'b0;
    xfer(1'b1, a_flg, 32'h2);
    rd(a_flg, 32'h0);
    note("locked map");
    foreach (rates[i])
    begin
      xfer(1'b1, a_rate, {28'h0, rates[i]});
      rd(a_rate, {28'h0, rates[i]});
      chk({28'h0, quad_group_second_mode, quad_group_first_mode}, {28'h0, rates[i]});
    end
    group_b_alarm <= 4'ha;
    xfer(1'b1, a_alm, 32'hf);
    rd(a_alm, 32'ha);
    rd(a_rsv, 32'h0);
    xfer(1'b1, a_ena, 32'h0);
    xfer(1'b0, 20'hc0100, 32'h0);
    chk({rdat[30:0], perr}, 32'h1);
    note("rate alarms and unmapped");
    close_out();
  end
endmodule // core_global_status_mode_regs_tb_top
`default_nettype wire
